// file: pkg/pmt_cfg.svh
// constants for the program memory and table read unit
// assumes includers also import pmt_pkg for the matching types
`ifndef PMT_CFG_SVH
`define PMT_CFG_SVH

`define PMT_AW 15
`define PMT_DEPTH 32768
`define PMT_RESET_VECTOR 15'h0000
`define PMT_LAST_PAGE 7'h7F
`define PMT_HI_W 7
`define PMT_SECT_W 3
`define PMT_OFS_W 8
`define PMT_SECT0 3'h0
`define PMT_THL_MASK 8'hFF
`define PMT_THL_RST 8'h00
`define PMT_TP_RST 8'h00
`define PMT_ST_W 4
`define PMT_ST_RST 4'h0
`define PMT_ST_C 0
`define PMT_ST_AC 1
`define PMT_ST_Z 2
`define PMT_ST_OV 3
`define PMT_TBL_CYCLES 2

`endif

// file: pkg/pmt_pkg.sv
// types shared by the table read unit and its alu
// assumes the constants of pmt_cfg.svh for widths
package pmt_pkg;

    // alu operations, the M forms are chosen by the destination select
    typedef enum logic [4:0]
    {
        PMT_ADD = 5'h00,
        PMT_ADC = 5'h01,
        PMT_SUB = 5'h02,
        PMT_SBC = 5'h03,
        PMT_DECIMAL_ADJUST_OP = 5'h04,
        PMT_AND = 5'h05,
        PMT_OR = 5'h06,
        PMT_XOR = 5'h07,
        PMT_CPL = 5'h08,
        PMT_RR = 5'h09,
        PMT_RRC = 5'h0A,
        PMT_RL = 5'h0B,
        PMT_RLC = 5'h0C,
        PMT_INC = 5'h0D,
        PMT_DEC = 5'h0E,
        PMT_SZ = 5'h0F,
        PMT_SNZ = 5'h10,
        PMT_SIZ = 5'h11,
        PMT_SDZ = 5'h12
    } pmt_alu_op_t;

    // table read forms
    typedef enum logic [1:0]
    {
        PMT_TR_SHORT = 2'h0,
        PMT_TR_SHORT_LAST = 2'h1,
        PMT_TR_EXT_TABLE_READ_OP = 2'h2,
        PMT_TR_EXT_LAST = 2'h3
    } pmt_tr_op_t;

    // table read sequencer
    typedef enum logic [1:0]
    {
        PMT_S_IDLE = 2'b00,
        PMT_S_READ = 2'b01
    } pmt_state_t;

endpackage : pmt_pkg

// file: hdl/pmt_alu.sv
// 8-bit alu with status outputs
// assumes the caller registers every result it uses
`timescale 1ns/100ps
`include "pmt_cfg.svh"
module pmt_alu
    import pmt_pkg::*;
(
    input wire pmt_alu_op_t op_i,
    input wire logic [7:0] a_i,
    input wire logic [7:0] m_i,
    input wire logic [`PMT_ST_W-1:0] st_i,
    output logic [7:0] res_o,
    output logic [`PMT_ST_W-1:0] st_o,
    output logic wr_o,
    output logic skip_o
);

    logic [7:0] b;
    logic cin;
    logic [8:0] sum;
    logic [4:0] nib;
    logic [8:0] adj;

    // one shared adder: subtraction adds the complement, carry = no borrow
    always_comb
    begin
        b = m_i;
        cin = 1'b0;
        unique case (op_i)
            PMT_ADC: cin = st_i[`PMT_ST_C];
            PMT_SUB:
            begin
                b = ~m_i;
                cin = 1'b1;
            end
            PMT_SBC:
            begin
                b = ~m_i;
                cin = st_i[`PMT_ST_C];
            end
            default: cin = 1'b0;
        endcase
        sum = {1'b0, a_i} + {1'b0, b} + {8'h00, cin};
        nib = {1'b0, a_i[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
    end

    // result, flags and skip decision
    always_comb
    begin
        res_o = sum[7:0];
        st_o = st_i;
        wr_o = 1'b1;
        skip_o = 1'b0;
        adj = {1'b0, a_i};
        unique case (op_i)
            PMT_ADD, PMT_ADC, PMT_SUB, PMT_SBC:
            begin
                st_o[`PMT_ST_C] = sum[8];
                st_o[`PMT_ST_AC] = nib[4];
                st_o[`PMT_ST_OV] = (a_i[7] == b[7]) && (sum[7] != a_i[7]);
            end
            PMT_DECIMAL_ADJUST_OP:
            begin
                if (a_i[3:0] > 4'h9 || st_i[`PMT_ST_AC])
                    adj = adj + 9'h006;
                if (adj[8:4] > 5'h09 || st_i[`PMT_ST_C])
                    adj = adj + 9'h060;
                res_o = adj[7:0];
                st_o[`PMT_ST_C] = adj[8] | st_i[`PMT_ST_C];
            end
            PMT_AND: res_o = a_i & m_i;
            PMT_OR: res_o = a_i | m_i;
            PMT_XOR: res_o = a_i ^ m_i;
            PMT_CPL: res_o = ~m_i;
            PMT_RR: res_o = {m_i[0], m_i[7:1]};
            PMT_RL: res_o = {m_i[6:0], m_i[7]};
            PMT_RRC:
            begin
                res_o = {st_i[`PMT_ST_C], m_i[7:1]};
                st_o[`PMT_ST_C] = m_i[0];
            end
            PMT_RLC:
            begin
                res_o = {m_i[6:0], st_i[`PMT_ST_C]};
                st_o[`PMT_ST_C] = m_i[7];
            end
            PMT_INC, PMT_SIZ: res_o = m_i + 8'h01;
            PMT_DEC, PMT_SDZ: res_o = m_i - 8'h01;
            PMT_SZ, PMT_SNZ:
            begin
                res_o = m_i;
                wr_o = 1'b0;
            end
            // unused op codes fall back to the adder and write it
            default: res_o = sum[7:0];
        endcase
        // zero flag on logic and step ops, skip ops leave status alone
        unique case (op_i)
            PMT_ADD, PMT_ADC, PMT_SUB, PMT_SBC, PMT_DECIMAL_ADJUST_OP,
            PMT_AND, PMT_OR, PMT_XOR, PMT_CPL, PMT_INC, PMT_DEC:
                st_o[`PMT_ST_Z] = (res_o == 8'h00);
            PMT_SZ, PMT_SIZ, PMT_SDZ:
                skip_o = (res_o == 8'h00);
            PMT_SNZ:
                skip_o = (res_o != 8'h00);
            default: skip_o = 1'b0;
        endcase
    end

endmodule : pmt_alu

// file: hdl/pmt_table_read_unit.sv
// program store, fetch address, table read path and alu write-back
// assumes the decoder holds requests to one per idle cycle and waits
// while busy_o is high; all inputs are synchronous to clk_i
`timescale 1ns/100ps
`include "pmt_cfg.svh"
module pmt_table_read_unit
    import pmt_pkg::*;
(
    input wire logic clk_i,
    input wire logic reset_n_i,
    // store loading port
    input wire logic prog_we_i,
    input wire logic [`PMT_AW-1:0] prog_addr_i,
    input wire logic [15:0] prog_data_i,
    // instruction fetch
    input wire logic fetch_i,
    input wire logic jump_i,
    input wire logic [`PMT_AW-1:0] jump_addr_i,
    output logic [`PMT_AW-1:0] pc_o,
    output logic [15:0] instr_o,
    // table pointers and latch, software side
    input wire logic tp_lo_we_i,
    input wire logic tp_hi_we_i,
    input wire logic thl_we_i,
    input wire logic [7:0] sfr_wdata_i,
    output logic [7:0] tp_lo_o,
    output logic [`PMT_HI_W-1:0] tp_hi_o,
    output logic [7:0] table_high_latch_o,
    // table read request
    input wire logic tr_valid_i,
    input wire pmt_tr_op_t tr_op_i,
    input wire logic [`PMT_SECT_W-1:0] dest_sect_i,
    input wire logic [`PMT_OFS_W-1:0] dest_ofs_i,
    // alu request
    input wire logic alu_valid_i,
    input wire pmt_alu_op_t alu_op_i,
    input wire logic alu_to_mem_i,
    input wire logic [7:0] alu_m_i,
    input wire logic acc_we_i,
    input wire logic status_we_i,
    // results
    output logic [`PMT_ST_W-1:0] status_o,
    output logic [7:0] acc_o,
    output logic skip_o,
    output logic busy_o,
    output logic done_o,
    output logic dm_we_o,
    output logic [`PMT_SECT_W-1:0] dm_sect_o,
    output logic [`PMT_OFS_W-1:0] dm_ofs_o,
    output logic [7:0] dm_wdata_o
);

    // program store; the whole array is local to this unit
    logic [15:0] mem [0:`PMT_DEPTH-1];

    pmt_state_t state_q, state_d;
    logic [`PMT_AW-1:0] pc_q, pc_d;
    logic [15:0] instr_q, instr_d;
    logic [7:0] tp_lo_q, tp_lo_d;
    logic [`PMT_HI_W-1:0] tp_hi_q, tp_hi_d;
    logic [7:0] thl_q, thl_d;
    logic [`PMT_AW-1:0] taddr_q, taddr_d;
    logic [`PMT_SECT_W-1:0] sect_q, sect_d;
    logic [`PMT_OFS_W-1:0] ofs_q, ofs_d;
    logic [`PMT_ST_W-1:0] st_q, st_d;
    logic [7:0] acc_q, acc_d;
    logic skip_q, skip_d;
    logic busy_q, busy_d;
    logic done_q, done_d;
    logic dm_we_q, dm_we_d;
    logic [`PMT_SECT_W-1:0] dm_sect_q, dm_sect_d;
    logic [`PMT_OFS_W-1:0] dm_ofs_q, dm_ofs_d;
    logic [7:0] dm_wdata_q, dm_wdata_d;

    logic tr_take;
    logic alu_take;
    logic [15:0] tword;
    logic [`PMT_HI_W-1:0] hi_sel;
    logic [7:0] alu_res;
    logic [`PMT_ST_W-1:0] alu_st;
    logic alu_wr;
    logic alu_skip;

    pmt_alu u_alu
    (
        .op_i(alu_op_i),
        .a_i(acc_q),
        .m_i(alu_m_i),
        .st_i(st_q),
        .res_o(alu_res),
        .st_o(alu_st),
        .wr_o(alu_wr),
        .skip_o(alu_skip)
    );

    // loading port; contents are not reset, as with a real store
    always_ff @(posedge clk_i)
    begin
        if (prog_we_i)
            mem[prog_addr_i] <= prog_data_i;
    end

    // request acceptance: a table read wins over an alu op when both come
    always_comb
    begin
        tr_take = (state_q == PMT_S_IDLE) && tr_valid_i;
        alu_take = (state_q == PMT_S_IDLE) && alu_valid_i && !tr_valid_i;
        tword = mem[taddr_q];
    end

    // fetch address and instruction word
    always_comb
    begin
        pc_d = pc_q;
        instr_d = instr_q;
        if (jump_i)
            pc_d = jump_addr_i;
        else if (fetch_i)
        begin
            instr_d = mem[pc_q];
            pc_d = pc_q + `PMT_AW'(1);
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            pc_q <= `PMT_RESET_VECTOR;
            instr_q <= 16'h0000;
        end
        else
        begin
            pc_q <= pc_d;
            instr_q <= instr_d;
        end
    end

    // table pointers and the shared high-byte latch
    always_comb
    begin
        tp_lo_d = tp_lo_q;
        tp_hi_d = tp_hi_q;
        thl_d = thl_q;
        if (tp_lo_we_i)
            tp_lo_d = sfr_wdata_i;
        if (tp_hi_we_i)
            tp_hi_d = sfr_wdata_i[`PMT_HI_W-1:0];
        if (thl_we_i)
            thl_d = sfr_wdata_i;
        // hardware load wins over a software write in the same cycle
        if (state_q == PMT_S_READ)
            thl_d = tword[15:8] & `PMT_THL_MASK;
    end

    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            tp_lo_q <= `PMT_TP_RST;
            tp_hi_q <= `PMT_HI_W'(`PMT_TP_RST);
            thl_q <= `PMT_THL_RST;
        end
        else
        begin
            tp_lo_q <= tp_lo_d;
            tp_hi_q <= tp_hi_d;
            thl_q <= thl_d;
        end
    end

    // table sequencer: take in idle, read and write back in the next cycle
    always_comb
    begin
        state_d = state_q;
        taddr_d = taddr_q;
        sect_d = sect_q;
        ofs_d = ofs_q;
        hi_sel = tp_hi_q;
        if (tr_op_i == PMT_TR_SHORT_LAST || tr_op_i == PMT_TR_EXT_LAST)
            hi_sel = `PMT_LAST_PAGE;
        unique case (state_q)
            PMT_S_IDLE:
            begin
                if (tr_take)
                begin
                    state_d = PMT_S_READ;
                    taddr_d = {hi_sel, tp_lo_q};
                    ofs_d = dest_ofs_i;
                    // short forms carry no sector, so they land in sector 0
                    if (tr_op_i == PMT_TR_SHORT ||
                        tr_op_i == PMT_TR_SHORT_LAST)
                        sect_d = `PMT_SECT0;
                    else
                        sect_d = dest_sect_i;
                end
            end
            PMT_S_READ: state_d = PMT_S_IDLE;
            default: state_d = PMT_S_IDLE;
        endcase
    end

    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            state_q <= PMT_S_IDLE;
            taddr_q <= `PMT_RESET_VECTOR;
            sect_q <= `PMT_SECT0;
            ofs_q <= `PMT_OFS_W'(0);
        end
        else
        begin
            state_q <= state_d;
            taddr_q <= taddr_d;
            sect_q <= sect_d;
            ofs_q <= ofs_d;
        end
    end

    // accumulator, status and the shared data-memory write port
    always_comb
    begin
        acc_d = acc_q;
        st_d = st_q;
        skip_d = 1'b0;
        dm_we_d = 1'b0;
        dm_sect_d = dm_sect_q;
        dm_ofs_d = dm_ofs_q;
        dm_wdata_d = dm_wdata_q;
        done_d = 1'b0;
        if (acc_we_i)
            acc_d = sfr_wdata_i;
        if (status_we_i)
            st_d = sfr_wdata_i[`PMT_ST_W-1:0];
        if (state_q == PMT_S_READ)
        begin
            dm_we_d = 1'b1;
            dm_sect_d = sect_q;
            dm_ofs_d = ofs_q;
            dm_wdata_d = tword[7:0];
            done_d = 1'b1;
        end
        else if (alu_take)
        begin
            st_d = alu_st;
            skip_d = alu_skip;
            done_d = 1'b1;
            if (alu_wr && alu_to_mem_i)
            begin
                dm_we_d = 1'b1;
                dm_sect_d = dest_sect_i;
                dm_ofs_d = dest_ofs_i;
                dm_wdata_d = alu_res;
            end
            else if (alu_wr)
                acc_d = alu_res;
        end
        busy_d = (state_d == PMT_S_READ);
    end

    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            acc_q <= 8'h00;
            st_q <= `PMT_ST_RST;
            skip_q <= 1'b0;
            busy_q <= 1'b0;
            done_q <= 1'b0;
            dm_we_q <= 1'b0;
            dm_sect_q <= `PMT_SECT0;
            dm_ofs_q <= `PMT_OFS_W'(0);
            dm_wdata_q <= 8'h00;
        end
        else
        begin
            acc_q <= acc_d;
            st_q <= st_d;
            skip_q <= skip_d;
            busy_q <= busy_d;
            done_q <= done_d;
            dm_we_q <= dm_we_d;
            dm_sect_q <= dm_sect_d;
            dm_ofs_q <= dm_ofs_d;
            dm_wdata_q <= dm_wdata_d;
        end
    end

    // every output straight from a flip-flop
    assign pc_o = pc_q;
    assign instr_o = instr_q;
    assign tp_lo_o = tp_lo_q;
    assign tp_hi_o = tp_hi_q;
    assign table_high_latch_o = thl_q;
    assign status_o = st_q;
    assign acc_o = acc_q;
    assign skip_o = skip_q;
    assign busy_o = busy_q;
    assign done_o = done_q;
    assign dm_we_o = dm_we_q;
    assign dm_sect_o = dm_sect_q;
    assign dm_ofs_o = dm_ofs_q;
    assign dm_wdata_o = dm_wdata_q;

endmodule : pmt_table_read_unit

// file: tb/pmt_chk_assertions.sv
// port assertions for the table read unit
// assumes it is bound onto pmt_table_read_unit, one clock domain
`timescale 1ns/100ps
`include "pmt_cfg.svh"
module pmt_chk_assertions
    import pmt_pkg::*;
(
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic fetch_i,
    input wire logic jump_i,
    input wire logic [`PMT_AW-1:0] pc_o,
    input wire logic thl_we_i,
    input wire logic [7:0] sfr_wdata_i,
    input wire logic [7:0] table_high_latch_o,
    input wire logic tr_valid_i,
    input wire pmt_tr_op_t tr_op_i,
    input wire logic [`PMT_SECT_W-1:0] dest_sect_i,
    input wire logic alu_valid_i,
    input wire pmt_alu_op_t alu_op_i,
    input wire logic status_we_i,
    input wire logic [`PMT_ST_W-1:0] status_o,
    input wire logic busy_o,
    input wire logic done_o,
    input wire logic dm_we_o,
    input wire logic [`PMT_SECT_W-1:0] dm_sect_o
);
    default clocking @(posedge clk_i);
    endclocking
    default disable iff (!reset_n_i);
    // requests taken at this edge; table read wins over the alu
    wire tr_go = tr_valid_i && !busy_o;
    wire alu_go = alu_valid_i && !tr_valid_i && !busy_o;

    tr_busy_a: assert property (
        tr_go |=> busy_o ##1 !busy_o)
        else $error("table read busy length wrong");
    tr_done_a: assert property (
        tr_go |-> ##2 done_o && dm_we_o)
        else $error("table read write-back not on time");
    short_sect_a: assert property (
        tr_go && !tr_op_i[1] |-> ##2 dm_sect_o == `PMT_SECT0)
        else $error("short table read left sector 0");
    ext_sect_a: assert property (
        tr_go && tr_op_i[1] |-> ##2 dm_sect_o == $past(dest_sect_i, 2))
        else $error("extended table read sector wrong");
    reset_vec_a: assert property (
        !$past(reset_n_i) |-> pc_o == `PMT_RESET_VECTOR)
        else $error("fetch not at reset vector");
    pc_step_a: assert property (
        fetch_i && !jump_i |=> pc_o == $past(pc_o) + 15'h0001)
        else $error("fetch address did not step");
    thl_sw_a: assert property (
        thl_we_i && !busy_o |=> table_high_latch_o == $past(sfr_wdata_i))
        else $error("latch software write lost");
    skip_flags_a: assert property (
        alu_go && alu_op_i >= PMT_SZ && !status_we_i |=> $stable(status_o))
        else $error("skip operation changed flags");
    alu_done_a: assert property (
        alu_go |=> done_o)
        else $error("alu request not completed");
endmodule : pmt_chk_assertions

bind pmt_table_read_unit pmt_chk_assertions u_chk (.*);

// file: tb/pmt_dmem_model.sv
// data memory model at the far side of the write-back port
// assumes one write pulse per request, synchronous to clk_i
`timescale 1ns/100ps
module pmt_dmem_model
(
    input wire logic clk_i,
    input wire logic we_i,
    input wire logic [2:0] sect_i,
    input wire logic [7:0] ofs_i,
    input wire logic [7:0] wdata_i
);
    logic [7:0] mem [0:2047];
    // sector and offset form the byte address, no wait states
    always @(posedge clk_i)
    begin
        if (we_i)
            mem[{sect_i, ofs_i}] <= wdata_i;
    end
endmodule : pmt_dmem_model

// file: tb/tb.sv
// self-checking bench for pmt_table_read_unit
// assumes package, config header, model and checker compiled first
`timescale 1ns/100ps
`include "pmt_cfg.svh"
`define CHK(n, e, s) chk(n, 16'(e), 16'(s))
module tb;
    import pmt_pkg::*;
    logic clk_i = 1'b0;
    logic reset_n_i, prog_we_i, fetch_i, jump_i, tp_lo_we_i, tp_hi_we_i;
    logic thl_we_i, tr_valid_i, alu_valid_i, alu_to_mem_i, acc_we_i;
    logic status_we_i, skip_o, busy_o, done_o, dm_we_o;
    logic [`PMT_AW-1:0] prog_addr_i, jump_addr_i, pc_o, ad;
    logic [15:0] prog_data_i, instr_o, rnd;
    logic [7:0] sfr_wdata_i, tp_lo_o, table_high_latch_o, alu_m_i, acc_o;
    logic [7:0] dest_ofs_i, dm_ofs_o, dm_wdata_o, hl, lv;
    logic [6:0] tp_hi_o;
    logic [2:0] dest_sect_i, dm_sect_o;
    logic [3:0] status_o;
    logic [10:0] ld;
    pmt_tr_op_t tr_op_i;
    pmt_alu_op_t alu_op_i;
    logic [15:0] rom [0:32767];
    int bad_count = 0;
    int compares = 0;
    int cyc = 0;

    pmt_table_read_unit u_dut (.*);
    pmt_dmem_model u_mem (.clk_i(clk_i), .we_i(dm_we_o),
        .sect_i(dm_sect_o), .ofs_i(dm_ofs_o), .wdata_i(dm_wdata_o));

    // 4 ns clock; the ceiling is several times the expected run
    always #2 clk_i = ~clk_i;
    always @(posedge clk_i)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            bad_count++;
            end_sim();
        end
    end

    task automatic chk(string n, logic [15:0] e, logic [15:0] s);
        compares++;
        if (s !== e)
        begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", n, e, s);
        end
    endtask : chk

    task automatic end_sim();
        $display("compares %0d bad_count %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : end_sim

    function automatic logic [15:0] nxt(logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : nxt

    // {skip, carry, zero, result}; untouched flags keep their old value
    function automatic logic [10:0] ref_alu(pmt_alu_op_t op,
        logic [7:0] a, logic [7:0] m, logic c);
        logic [8:0] r;
        logic z;
        logic k;
        r = {c, a};
        case (op)
            PMT_ADD: r = a + m;
            PMT_ADC: r = a + m + c;
            PMT_SUB: r = a + {1'b0, ~m} + 9'h001;
            PMT_SBC: r = a + {1'b0, ~m} + c;
            // half carry is cleared by the status write before each op
            PMT_DECIMAL_ADJUST_OP:
            begin
                r = {1'b0, a} + (a[3:0] > 4'h9 ? 9'h006 : 9'h000);
                if (r[8:4] > 5'h09 || c)
                    r = r + 9'h060;
                r[8] = r[8] | c;
            end
            PMT_AND: r[7:0] = a & m;
            PMT_OR: r[7:0] = a | m;
            PMT_XOR: r[7:0] = a ^ m;
            PMT_CPL: r[7:0] = ~m;
            PMT_RR: r[7:0] = {m[0], m[7:1]};
            PMT_RRC: r = {m[0], c, m[7:1]};
            PMT_RL: r[7:0] = {m[6:0], m[7]};
            PMT_RLC: r = {m[7], m[6:0], c};
            PMT_INC, PMT_SIZ: r[7:0] = m + 8'h01;
            PMT_DEC, PMT_SDZ: r[7:0] = m - 8'h01;
            default: r[7:0] = a;
        endcase
        z = (op < PMT_RR || op == PMT_INC || op == PMT_DEC) && r[7:0] == 0;
        k = op == PMT_SZ ? m == 8'h00 : op == PMT_SNZ ? m != 8'h00 :
            op >= PMT_SIZ && r[7:0] == 8'h00;
        return {k, r[8], z, r[7:0]};
    endfunction : ref_alu

    // one software write: 0 low ptr, 1 high ptr, 2 latch, 3 acc, 4 status
    task automatic sfr(int k, logic [7:0] d);
        sfr_wdata_i = d;
        {status_we_i, acc_we_i, thl_we_i, tp_hi_we_i, tp_lo_we_i} = 5'(1 << k);
        @(negedge clk_i);
        {status_we_i, acc_we_i, thl_we_i, tp_hi_we_i, tp_lo_we_i} = 5'h00;
        // idle edge, so a next call never re-raises a strobe in this step
        @(negedge clk_i);
    endtask : sfr

    task automatic load(logic [14:0] a, logic [15:0] d);
        prog_we_i = 1'b1;
        prog_addr_i = a;
        prog_data_i = d;
        rom[a] = d;
        @(negedge clk_i);
        prog_we_i = 1'b0;
        @(negedge clk_i);
    endtask : load

    // table read at ad; an alu request in the busy cycle must be ignored
    task automatic tread(pmt_tr_op_t op);
        logic [7:0] ac;
        rnd = nxt(rnd);
        tr_valid_i = 1'b1;
        tr_op_i = op;
        dest_sect_i = rnd[10:8];
        dest_ofs_i = rnd[7:0];
        ac = acc_o;
        @(negedge clk_i);
        tr_valid_i = 1'b0;
        alu_valid_i = 1'b1;
        alu_op_i = PMT_INC;
        alu_to_mem_i = 1'b0;
        `CHK("busy", 1'b1, busy_o);
        @(negedge clk_i);
        alu_valid_i = 1'b0;
        ld = {op[1] ? dest_sect_i : 3'h0, dest_ofs_i};
        lv = rom[ad][7:0];
        hl = rom[ad][15:8];
        `CHK("done", 2'h3, {done_o, dm_we_o});
        `CHK("dest", ld, {dm_sect_o, dm_ofs_o});
        `CHK("low", lv, dm_wdata_o);
        `CHK("latch", hl, table_high_latch_o);
        `CHK("refuse", ac, acc_o);
    endtask : tread

    task automatic alu(pmt_alu_op_t op, logic [7:0] a, logic [7:0] m,
        logic c, logic tm);
        logic [10:0] e;
        e = ref_alu(op, a, m, c);
        sfr(3, a);
        sfr(4, {7'h00, c});
        alu_valid_i = 1'b1;
        alu_op_i = op;
        alu_m_i = m;
        alu_to_mem_i = tm;
        @(negedge clk_i);
        alu_valid_i = 1'b0;
        `CHK("alu_done", {1'b1, e[10]}, {done_o, skip_o});
        `CHK("alu_res", e[7:0], tm ? dm_wdata_o : acc_o);
        `CHK("carry", e[9], status_o[`PMT_ST_C]);
        `CHK("zero", e[8], status_o[`PMT_ST_Z]);
    endtask : alu

    initial
    begin
        {reset_n_i, prog_we_i, fetch_i, jump_i, tp_lo_we_i, tp_hi_we_i} = '0;
        {thl_we_i, tr_valid_i, alu_valid_i, alu_to_mem_i, acc_we_i} = '0;
        {status_we_i, prog_addr_i, jump_addr_i, prog_data_i} = '0;
        {sfr_wdata_i, alu_m_i, dest_ofs_i, dest_sect_i} = '0;
        tr_op_i = PMT_TR_SHORT;
        alu_op_i = PMT_ADD;
        rnd = 16'h005B;
        repeat (2) @(negedge clk_i);
        reset_n_i = 1'b1;
        // reset vector, then two sequential fetches
        `CHK("pc_rst", 15'h0000, pc_o);
        load(15'h0000, 16'hA55A);
        load(15'h0001, 16'h3C96);
        fetch_i = 1'b1;
        for (int i = 0; i < 2; i++)
        begin
            @(negedge clk_i);
            `CHK("instr", rom[i], instr_o);
        end
        fetch_i = 1'b0;
        jump_i = 1'b1;
        jump_addr_i = 15'h0001;
        @(negedge clk_i);
        jump_i = 1'b0;
        `CHK("jump", 15'h0001, pc_o);
        $display("test fetch done");
        // random table reads, corners first, every other one back to back
        for (int i = 0; i < 24; i++)
        begin
            rnd = nxt(rnd);
            if (i < 2)
                rnd = i ? 16'h7FFF : 16'h0000;
            ad = {rnd[i % 2] ? `PMT_LAST_PAGE : rnd[14:8],
                rnd[7:0]};
            sfr(0, rnd[7:0]);
            sfr(1, {1'b0, rnd[14:8]});
            `CHK("ptr", rnd[14:0], {tp_hi_o, tp_lo_o});
            load(ad, nxt(rnd));
            tread(pmt_tr_op_t'({rnd[i % 3 == 0], rnd[i % 2]}));
            // second read reuses the page choice of the first, same address
            if (i % 2)
                tread(pmt_tr_op_t'({~tr_op_i[1], tr_op_i[0]}));
        end
        @(negedge clk_i);
        `CHK("dmem", lv, u_mem.mem[ld]);
        $display("test table read done");
        // save and restore the latch as an interrupt handler must
        rnd = nxt(rnd);
        sfr(2, rnd[7:0]);
        `CHK("latch_wr", rnd[7:0], table_high_latch_o);
        sfr(2, hl);
        `CHK("latch_rs", hl, table_high_latch_o);
        $display("test latch done");
        // every alu operation: a carry corner, a zero operand, a random one
        for (int i = 0; i < 19; i++)
        begin
            for (int j = 0; j < 3; j++)
            begin
                rnd = nxt(rnd);
                if (j == 0)
                    rnd = 16'hFF01;
                if (j == 1)
                    rnd[7:0] = 8'h00;
                if (i == 4)
                    rnd[15:8] = 8'h42;
                alu(pmt_alu_op_t'(i), rnd[15:8], rnd[7:0], rnd[j + 3],
                    rnd[9] && (i < 15 || i > 16));
            end
        end
        $display("test alu done");
        // reset in the middle of a table read
        tr_valid_i = 1'b1;
        @(negedge clk_i);
        tr_valid_i = 1'b0;
        reset_n_i = 1'b0;
        @(negedge clk_i);
        reset_n_i = 1'b1;
        `CHK("pc_rst2", 15'h0000, pc_o);
        `CHK("idle_rst2", 9'h000, {busy_o, table_high_latch_o});
        fetch_i = 1'b1;
        @(negedge clk_i);
        fetch_i = 1'b0;
        `CHK("instr_rst2", rom[0], instr_o);
        $display("test reset done");
        end_sim();
    end
endmodule : tb
